//--- logic/acf_pkg.sv
package acf_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ACF_OFS_CFG = 8'hbc;
  localparam logic [7:0] ACF_OFS_LO  = 8'hbd;
  localparam logic [7:0] ACF_OFS_HI  = 8'hbe;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] ACF_RST_CFG = 8'hf9;
  localparam logic [7:0] ACF_RST_LO  = 8'h00;
  localparam logic [7:0] ACF_RST_HI  = 8'h00;
  localparam logic [7:0] ACF_RD_NONE = 8'h00;

  // ----------------------------------------
  // Field positions and counts
  // ----------------------------------------
  localparam int ACF_DIV_MSB  = 7;
  localparam int ACF_DIV_LSB  = 3;
  localparam int ACF_LJST_BIT = 2;
  localparam int ACF_8BIT_BIT = 1;
  localparam int ACF_GAIN_BIT = 0;
  localparam int ACF_RES_W    = 10;
  localparam int ACF_BITS_10  = 10;
  localparam int ACF_BITS_8   = 8;
  localparam int ACF_DLY_TICKS = 3;

  // Configuration register layout, bit 7 first
  typedef struct packed {
    logic [4:0] sar_clock_divider;
    logic       left_justify_select;
    logic       eight_bit_mode_select;
    logic       input_gain_select;
  } acf_cfg_t;

  // Special function register access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acf_sfr_t;

  typedef enum logic [1:0] {
    ACF_IDLE  = 2'b00,
    ACF_DELAY = 2'b01,
    ACF_CONV  = 2'b11,
    ACF_DONE  = 2'b10
  } acf_state_t;

endpackage

//--- logic/acf_top.sv
`timescale 1ns/10ps
// Function
// - SAR clock is system clock over divider+1
// - Bit 2 picks right or left justify
// - Justify bit ignored in 8-bit mode
// - Bit 1 picks 10-bit or 8-bit mode
// - Bit 0 picks gain 0.5 or 1
// - Right justify: high byte holds top two bits
// - Left justify: high byte holds top eight bits
// - 8-bit mode: high byte holds whole result
// - Right justify: low byte holds low eight bits
// - Left justify: low byte bits 7:6, rest zero
// - 8-bit mode: low byte reads zero
// - Both result bytes update at conversion end
// - 8-bit conversion two SAR clocks shorter
// - Delayed tracking adds three SAR clocks first
module acf_top
  import acf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire acf_pkg::acf_sfr_t sfr,
  output logic [7:0]             sfr_rdata_q,
  input  wire logic              conv_start,
  input  wire logic              delayed_track_select,
  input  wire logic              comp_in,
  output logic [9:0]             dac_code_q,
  output logic                   gain_q,
  output logic                   track_q,
  output logic                   busy_q,
  output logic                   done_q
);
  import acf_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  acf_cfg_t   cfg_q,   cfg_d;
  logic [7:0] hi_q,    hi_d;
  logic [7:0] lo_q,    lo_d;
  logic [7:0] rdata_d;
  acf_state_t state_q, state_d;
  logic [4:0] cnt_q,   cnt_d;
  logic [3:0] idx_q,   idx_d;
  logic [1:0] dly_q,   dly_d;
  logic [3:0] nticks_q, nticks_d;
  logic [9:0] code_d;
  logic       conv8_q, conv8_d;
  logic       ljst_q,  ljst_d;
  logic       done_d;
  logic       comp_m_q, comp_s_q;
  logic       tick;
  logic       wr_cfg, wr_lo, wr_hi;
  logic [3:0] last_idx;

  // ----------------------------------------
  // Decode and SAR clock enable
  // ----------------------------------------
  always_comb
  begin
    wr_cfg = 1'b0;
    wr_lo  = 1'b0;
    wr_hi  = 1'b0;
    if (sfr.wr && sfr.addr == ACF_OFS_CFG)
    begin
      wr_cfg = 1'b1;
    end
    else if (sfr.wr && sfr.addr == ACF_OFS_LO)
    begin
      wr_lo = 1'b1;
    end
    else if (sfr.wr && sfr.addr == ACF_OFS_HI)
    begin
      wr_hi = 1'b1;
    end
  end

  assign tick     = (cnt_q >= cfg_q.sar_clock_divider);
  assign last_idx = conv8_q ? 4'(ACF_BITS_10 - ACF_BITS_8) : 4'h0;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    cfg_d    = cfg_q;
    hi_d     = hi_q;
    lo_d     = lo_q;
    rdata_d  = sfr_rdata_q;
    state_d  = state_q;
    cnt_d    = tick ? 5'h00 : cnt_q + 5'h01;
    idx_d    = idx_q;
    dly_d    = dly_q;
    nticks_d = nticks_q;
    code_d   = dac_code_q;
    conv8_d  = conv8_q;
    ljst_d   = ljst_q;
    done_d   = 1'b0;
    if (wr_cfg)
    begin
      cfg_d = acf_cfg_t'(sfr.wdata);
    end
    if (wr_lo)
    begin
      lo_d = sfr.wdata;
    end
    if (wr_hi)
    begin
      hi_d = sfr.wdata;
    end
    if (sfr.rd)
    begin
      if (sfr.addr == ACF_OFS_CFG)
      begin
        rdata_d = cfg_q;
      end
      else if (sfr.addr == ACF_OFS_LO)
      begin
        rdata_d = lo_q;
      end
      else if (sfr.addr == ACF_OFS_HI)
      begin
        rdata_d = hi_q;
      end
      else
      begin
        rdata_d = ACF_RD_NONE;
      end
    end
    case (state_q)
      ACF_IDLE:
      begin
        if (conv_start && !done_q)
        begin
          cnt_d    = 5'h00;
          conv8_d  = cfg_q.eight_bit_mode_select;
          ljst_d   = cfg_q.left_justify_select;
          dly_d    = 2'h0;
          nticks_d = 4'h0;
          idx_d    = 4'(ACF_RES_W - 1);
          code_d   = 10'h200;
          state_d  = delayed_track_select ? ACF_DELAY : ACF_CONV;
        end
      end
      ACF_DELAY:
      begin
        if (tick)
        begin
          dly_d = dly_q + 2'h1;
          if (dly_q == 2'(ACF_DLY_TICKS - 1))
          begin
            state_d = ACF_CONV;
          end
        end
      end
      ACF_CONV:
      begin
        if (tick)
        begin
          nticks_d       = nticks_q + 4'h1;
          code_d[idx_q]  = comp_s_q;
          if (idx_q == last_idx)
          begin
            state_d = ACF_DONE;
          end
          else
          begin
            idx_d             = idx_q - 4'h1;
            code_d[idx_q - 4'h1] = 1'b1;
          end
        end
      end
      ACF_DONE:
      begin
        done_d  = 1'b1;
        state_d = ACF_IDLE;
        if (conv8_q)
        begin
          hi_d = dac_code_q[9:2];
          lo_d = 8'h00;
        end
        else if (ljst_q)
        begin
          hi_d = dac_code_q[9:2];
          lo_d = {dac_code_q[1:0], 6'h00};
        end
        else
        begin
          hi_d = {6'h00, dac_code_q[9:8]};
          lo_d = dac_code_q[7:0];
        end
      end
      default:
      begin
        state_d = ACF_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg_q       <= ACF_RST_CFG;
      hi_q        <= ACF_RST_HI;
      lo_q        <= ACF_RST_LO;
      sfr_rdata_q <= 8'h00;
      state_q     <= ACF_IDLE;
      cnt_q       <= 5'h00;
      idx_q       <= 4'h0;
      dly_q       <= 2'h0;
      nticks_q    <= 4'h0;
      dac_code_q  <= 10'h000;
      conv8_q     <= 1'b0;
      ljst_q      <= 1'b0;
      done_q      <= 1'b0;
      gain_q      <= 1'b1;
      track_q     <= 1'b1;
      busy_q      <= 1'b0;
      comp_m_q    <= 1'b0;
      comp_s_q    <= 1'b0;
    end
    else
    begin
      cfg_q       <= cfg_d;
      hi_q        <= hi_d;
      lo_q        <= lo_d;
      sfr_rdata_q <= rdata_d;
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      idx_q       <= idx_d;
      dly_q       <= dly_d;
      nticks_q    <= nticks_d;
      dac_code_q  <= code_d;
      conv8_q     <= conv8_d;
      ljst_q      <= ljst_d;
      done_q      <= done_d;
      gain_q      <= cfg_d.input_gain_select;
      track_q     <= (state_d == ACF_IDLE) || (state_d == ACF_DELAY);
      busy_q      <= (state_d != ACF_IDLE);
      comp_m_q    <= comp_in;
      comp_s_q    <= comp_m_q;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_start_dly;
    state_q == ACF_IDLE && conv_start && !done_q && delayed_track_select;
  endsequence

  sequence s_dly_end;
    state_q == ACF_DELAY && tick && dly_q == 2'(ACF_DLY_TICKS - 1);
  endsequence

  a_div_restart: assert property (tick |=> cnt_q == 5'h00)
    else $error("SAR divider did not restart");
  a_track_delay: assert property (s_start_dly |=> state_q == ACF_DELAY)
    else $error("Delayed start skipped tracking");
  a_delay_exit: assert property (s_dly_end |=> state_q == ACF_CONV ##0 busy_q)
    else $error("Tracking delay length wrong");
  a_conv_len: assert property (
      state_q == ACF_CONV && state_d == ACF_DONE
      |-> nticks_d == (conv8_q ? 4'(ACF_BITS_8) : 4'(ACF_BITS_10)))
    else $error("Conversion length wrong");
  a_mode_latch: assert property (
      state_q == ACF_IDLE && conv_start && !done_q
      |=> conv8_q == $past(cfg_q.eight_bit_mode_select))
    else $error("Resolution not captured at start");
  a_right_fmt: assert property (
      done_q && !conv8_q && !ljst_q
      |-> hi_q == {6'h00, dac_code_q[9:8]} && lo_q == dac_code_q[7:0])
    else $error("Right justified layout wrong");
  a_left_fmt: assert property (
      done_q && !conv8_q && ljst_q
      |-> hi_q == dac_code_q[9:2] && lo_q == {dac_code_q[1:0], 6'h00})
    else $error("Left justified layout wrong");
  a_eight_fmt: assert property (
      done_q && conv8_q |-> hi_q == dac_code_q[9:2] && lo_q == 8'h00)
    else $error("8-bit layout wrong");
  a_done_pulse: assert property (done_q |=> !done_q ##0 !busy_q)
    else $error("Done not a single pulse");
  a_sw_hold: assert property (
      state_q != ACF_DONE && !wr_hi |=> $stable(hi_q))
    else $error("High result changed without cause");
  a_sw_write: assert property (
      state_q != ACF_DONE && wr_lo |=> lo_q == $past(sfr.wdata))
    else $error("Low result write lost");
  a_gain_follow: assert property (gain_q == cfg_q.input_gain_select)
    else $error("Gain output out of step");

endmodule

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import acf_pkg::*;
  logic       clk;
  logic       rst_n;
  acf_sfr_t   sfr;
  logic [7:0] sfr_rdata_q;
  logic       conv_start;
  logic       delayed_track_select;
  logic       comp_in;
  logic [9:0] dac_code_q;
  logic       gain_q;
  logic       track_q;
  logic       busy_q;
  logic       done_q;
  int         mismatches = 0;
  int         tests_run  = 0;
  int         cyc        = 0;
  int         tgt        = 0;
  int         dv, lj, m8, dl, gn, n, i;
  logic [7:0] rv;

  acf_top i_acf_top (
    .clk                  (clk),
    .rst_n                (rst_n),
    .sfr                  (sfr),
    .sfr_rdata_q          (sfr_rdata_q),
    .conv_start           (conv_start),
    .delayed_track_select (delayed_track_select),
    .comp_in              (comp_in),
    .dac_code_q           (dac_code_q),
    .gain_q               (gain_q),
    .track_q              (track_q),
    .busy_q               (busy_q),
    .done_q               (done_q)
  );

  // ----------------------------------------
  // Clock, analog input model, timeout
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    comp_in <= (tgt >= int'(dac_code_q));
    cyc     <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    sfr <= '0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    sfr <= '0;
    @(negedge clk);
    rv = sfr_rdata_q;
    chk(16'(exp), 16'(rv));
  endtask

  task automatic conv();
    @(posedge clk);
    conv_start           <= 1'b1;
    delayed_track_select <= 1'(dl);
    @(posedge clk);
    conv_start <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      if (n == 1)
      begin
        chk(16'h0001, 16'(busy_q));
        chk(16'(dl), 16'(track_q));
      end
    end
    while (done_q !== 1'b1 && n < 300);
    chk(16'h0000, 16'(busy_q));
    chk(16'h0001, 16'(track_q));
    chk(16'(m8 ? (tgt / 4) * 4 : tgt), 16'(dac_code_q));
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    sfr                  = '0;
    conv_start           = 1'b0;
    delayed_track_select = 1'b0;
    comp_in              = 1'b0;
    rst_n                = 1'b0;
    rv                   = 8'($urandom(23729));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rchk(ACF_OFS_CFG, ACF_RST_CFG);
    rchk(ACF_OFS_LO, ACF_RST_LO);
    rchk(ACF_OFS_HI, ACF_RST_HI);
    rchk(8'hbf, ACF_RD_NONE);
    chk(16'h0001, 16'(gain_q));
    for (i = 0; i < 8; i++)
    begin
      dv  = 3 + $urandom % 3;
      lj  = i % 2;
      m8  = (i / 2) % 2;
      dl  = i / 4;
      gn  = $urandom % 2;
      tgt = $urandom % 1024;
      wr(ACF_OFS_CFG, 8'(dv * 8 + lj * 4 + m8 * 2 + gn));
      wr(8'hbf, 8'h00);
      rchk(ACF_OFS_CFG, 8'(dv * 8 + lj * 4 + m8 * 2 + gn));
      chk(16'(gn), 16'(gain_q));
      conv();
      chk(16'(((m8 ? 8 : 10) + 3 * dl) * (dv + 1) + 2), 16'(n));
      rchk(ACF_OFS_HI, 8'((m8 || lj) ? tgt / 4 : tgt / 256));
      rchk(ACF_OFS_LO, 8'(m8 ? 0 : lj ? (tgt % 4) * 64 : tgt % 256));
      wr(ACF_OFS_HI, 8'(tgt));
      rchk(ACF_OFS_HI, 8'(tgt));
      wr(ACF_OFS_LO, 8'(tgt / 4));
      rchk(ACF_OFS_LO, 8'(tgt / 4));
    end
    end_sim();
  end
endmodule
